/* ubf_consts.svh */
// ubf_consts.svh - offsets, field positions, reset values and counts
// assumes: included by the package and design files of the ubf block
`ifndef UBF_CONSTS_SVH
`define UBF_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets on the bus
// ----------------------------------------------------------------
`define UBF_OFS_DIV 8'h00
`define UBF_OFS_FCR 8'h04
`define UBF_OFS_MODE 8'h08
`define UBF_OFS_CNT 8'h0C
`define UBF_OFS_TXD 8'h10
`define UBF_OFS_RXD 8'h14
`define UBF_OFS_STAT 8'h18
`define UBF_OFS_CLR 8'h1C
`define UBF_OFS_IEN 8'h20

// ----------------------------------------------------------------
// fifo_control fields
// ----------------------------------------------------------------
`define UBF_FCR_LOOP 0
`define UBF_FCR_RX_FIFO_RESET 1
`define UBF_FCR_TX_FIFO_RESET 2
`define UBF_FCR_MCE 3
`define UBF_FCR_TTRG 4
`define UBF_FCR_RTRG 6
`define UBF_FCR_RSTRG 8
`define UBF_FCR_W 11

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define UBF_DIV_RST 8'hFF
`define UBF_FCR_RST 11'h000

// ----------------------------------------------------------------
// status bits
// ----------------------------------------------------------------
`define UBF_ST_RXFULL 0
`define UBF_ST_TXEMPTY 1
`define UBF_ST_TXDROP 2
`define UBF_ST_RXOVR 3
`define UBF_ST_W 4

// ----------------------------------------------------------------
// fifo size and counts
// ----------------------------------------------------------------
`define UBF_DEPTH 5'h10
`define UBF_SMP_LAST 4'hF
`define UBF_PRE0 6'h00
`define UBF_PRE1 6'h03
`define UBF_PRE2 6'h0F
`define UBF_PRE3 6'h3F

`endif

/* ubf_pkg.sv */
// ubf_pkg.sv - types of the ubf block
// assumes: ubf_consts.svh is on the include path
`include "ubf_consts.svh"
package ubf_pkg;
	typedef logic [4:0] ubf_cnt_t;

	typedef enum logic [1:0] {
		UBF_BUS_IDLE = 2'b01,
		UBF_BUS_ACK = 2'b10
	} ubf_bus_t;

	typedef struct packed {
		logic [15:0][7:0] mem;
		logic [3:0] wp;
		logic [3:0] rp;
		ubf_cnt_t cnt;
	} ubf_fifo_st_t;

	typedef struct packed {
		ubf_bus_t bus;
		logic [31:0] rdat;
		logic [7:0] div;
		logic [`UBF_FCR_W-1:0] fcr;
		logic [1:0] cks;
		logic [`UBF_ST_W-1:0] stat;
		logic [`UBF_ST_W-1:0] ien;
		logic [5:0] pcnt;
		logic [7:0] dcnt;
		logic half;
		logic [3:0] scnt;
		logic stick;
		logic btick;
		logic rts;
	} ubf_regs_t;
endpackage

/* ubf_fifo.sv */
// ubf_fifo.sv - 16 x 8 byte fifo with valid/ready on both sides
// assumes: flush_i is high during reset; one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "ubf_consts.svh"
module ubf_fifo (
	input wire logic clk_i, // clock
	input wire logic flush_i, // empties the fifo
	input wire logic in_valid_i, // byte offered
	output logic in_ready_o, // room for a byte
	input wire logic [7:0] in_data_i, // byte in
	output logic out_valid_o, // byte available
	input wire logic out_ready_i, // byte taken
	output logic [7:0] out_data_o, // oldest byte
	output ubf_pkg::ubf_cnt_t count_o // bytes held
);
	import ubf_pkg::*;

	ubf_fifo_st_t st;
	ubf_fifo_st_t next_st;
	logic push;
	logic pop;

	assign in_ready_o = (st.cnt != `UBF_DEPTH) && !flush_i;
	assign out_valid_o = (st.cnt != 5'h00);
	assign out_data_o = st.mem[st.rp];
	assign count_o = st.cnt;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wp] = in_data_i;
			next_st.wp = st.wp + 4'h1;
		end
		if (pop) begin
			next_st.rp = st.rp + 4'h1;
		end
		case ({push, pop})
			2'b10: next_st.cnt = st.cnt + 5'h01;
			2'b01: next_st.cnt = st.cnt - 5'h01;
			default: next_st.cnt = st.cnt;
		endcase
		if (flush_i) begin
			next_st.wp = 4'h0;
			next_st.rp = 4'h0;
			next_st.cnt = 5'h00;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	default clocking cb @(posedge clk_i); endclocking

	flush_empty_a: assert property (flush_i |=> count_o == 5'h00)
		else $error("fifo not empty after flush");
	count_bound_a: assert property (disable iff (flush_i) count_o <= `UBF_DEPTH)
		else $error("fifo count above depth");
endmodule // ubf_fifo
`default_nettype wire

/* ubf_uart_ctrl.sv */
// ubf_uart_ctrl.sv - baud generator, fifo control and register bank
// assumes: classic wishbone master; shift engines sit outside and
// use the sample and bit ticks, the fifo streams and the serial taps
//
// How it works
// - eight-bit divisor with clock select sets rate
// - divisor resets to all ones
// - rate is clock over 64*2^(2n-1)*(N+1)
// - select codes give clock, /4, /16, /64
// - divisor readable and writable at any time
// - control register read/write, resets to zero
// - control bits 15 to 11 read zero
// - rts high when rx count exceeds threshold
// - rx full flag at count >= trigger
// - tx empty flag at count <= trigger
// - modem control off: cts low, rts zero
// - tx fifo reset bit empties tx fifo
// - rx fifo reset bit empties rx fifo
// - bus reset empties both fifos
// - loopback ties tx to rx, rts to cts
// - rx fifo 16 bytes, empty read undefined
// - count register: tx high, rx low byte
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ubf_consts.svh"
module ubf_uart_ctrl (
	input wire logic clk_i, // 250 MHz peripheral clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // bus strobe
	input wire logic wb_we_i, // write
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	output logic irq_o, // level interrupt
	output logic sample_tick_o, // 16x bit rate pulse
	output logic bit_tick_o, // bit rate pulse
	output logic tx_valid_o, // tx byte for engine
	input wire logic tx_ready_i, // engine takes tx byte
	output logic [7:0] tx_data_o, // tx byte
	input wire logic rx_valid_i, // engine offers rx byte
	output logic rx_ready_o, // rx fifo has room
	input wire logic [7:0] rx_data_i, // rx byte
	input wire logic tx_serial_i, // engine serial out
	output logic rx_serial_o, // serial into engine
	output logic cts_eff_n_o, // clear to send to engine, low active
	output logic serial_tx_pin_o, // tx pin
	input wire logic serial_rx_pin_i, // rx pin
	output logic request_to_send_out_o, // rts pin
	input wire logic clear_to_send_in_n_i // cts pin, low active
);
	import ubf_pkg::*;

	// ----------------------------------------------------------------
	// state and fifo wiring
	// ----------------------------------------------------------------
	ubf_regs_t r;
	ubf_regs_t next_r;
	ubf_cnt_t tx_cnt;
	ubf_cnt_t rx_cnt;
	logic [7:0] rx_byte;
	logic rx_avail;
	logic tx_room;
	logic req;
	logic rd_rx;
	logic wr_tx;
	logic tx_flush;
	logic rx_flush;
	logic [5:0] pre_max;
	logic pre_tick;
	logic [4:0] rts_thr;
	logic [4:0] rx_trg;
	logic [4:0] tx_trg;
	logic [`UBF_ST_W-1:0] events;
	logic [`UBF_ST_W-1:0] clr;
	logic modem_control_enable;
	logic loop;

	assign modem_control_enable = r.fcr[`UBF_FCR_MCE];
	assign loop = r.fcr[`UBF_FCR_LOOP];
	assign req = wb_cyc_i && wb_stb_i && (r.bus == UBF_BUS_IDLE);
	assign rd_rx = req && !wb_we_i && (wb_adr_i == `UBF_OFS_RXD);
	assign wr_tx = req && wb_we_i && (wb_adr_i == `UBF_OFS_TXD) && wb_sel_i[0];
	assign tx_flush = rst_i || r.fcr[`UBF_FCR_TX_FIFO_RESET];
	assign rx_flush = rst_i || r.fcr[`UBF_FCR_RX_FIFO_RESET];

	ubf_fifo u_tx_fifo (
		.clk_i(clk_i),
		.flush_i(tx_flush),
		.in_valid_i(wr_tx),
		.in_ready_o(tx_room),
		.in_data_i(wb_dat_i[7:0]),
		.out_valid_o(tx_valid_o),
		.out_ready_i(tx_ready_i),
		.out_data_o(tx_data_o),
		.count_o(tx_cnt)
	);

	// 16-deep receive store; an empty read returns a stale byte
	ubf_fifo u_rx_fifo (
		.clk_i(clk_i),
		.flush_i(rx_flush),
		.in_valid_i(rx_valid_i),
		.in_ready_o(rx_ready_o),
		.in_data_i(rx_data_i),
		.out_valid_o(rx_avail),
		.out_ready_i(rd_rx),
		.out_data_o(rx_byte),
		.count_o(rx_cnt)
	);

	// ----------------------------------------------------------------
	// trigger and threshold decode
	// ----------------------------------------------------------------
	always_comb begin
		case (r.fcr[`UBF_FCR_RSTRG +: 3])
			3'h0: rts_thr = 5'h0F;
			3'h1: rts_thr = 5'h01;
			3'h2: rts_thr = 5'h04;
			3'h3: rts_thr = 5'h06;
			3'h4: rts_thr = 5'h08;
			3'h5: rts_thr = 5'h0A;
			3'h6: rts_thr = 5'h0C;
			default: rts_thr = 5'h0E;
		endcase
		case (r.fcr[`UBF_FCR_RTRG +: 2])
			2'h0: rx_trg = 5'h01;
			2'h1: rx_trg = 5'h04;
			2'h2: rx_trg = 5'h08;
			default: rx_trg = 5'h0E;
		endcase
		case (r.fcr[`UBF_FCR_TTRG +: 2])
			2'h0: tx_trg = 5'h08;
			2'h1: tx_trg = 5'h04;
			2'h2: tx_trg = 5'h02;
			default: tx_trg = 5'h01;
		endcase
		case (r.cks)
			2'h0: pre_max = `UBF_PRE0;
			2'h1: pre_max = `UBF_PRE1;
			2'h2: pre_max = `UBF_PRE2;
			default: pre_max = `UBF_PRE3;
		endcase
	end

	assign pre_tick = (r.pcnt >= pre_max);

	// ----------------------------------------------------------------
	// events and clear strobes
	// ----------------------------------------------------------------
	always_comb begin
		events = '0;
		events[`UBF_ST_RXFULL] = (rx_cnt >= rx_trg);
		events[`UBF_ST_TXEMPTY] = (tx_cnt <= tx_trg);
		events[`UBF_ST_TXDROP] = req && wb_we_i && (wb_adr_i == `UBF_OFS_TXD) && !tx_room;
		events[`UBF_ST_RXOVR] = rx_valid_i && !rx_ready_o;
		clr = '0;
		if (req && wb_we_i && (wb_adr_i == `UBF_OFS_CLR) && wb_sel_i[0]) begin
			clr = wb_dat_i[`UBF_ST_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.stick = 1'b0;
		next_r.btick = 1'b0;

		// bus: one wait state, answer in the following cycle
		case (r.bus)
			UBF_BUS_IDLE: begin
				if (req) begin
					next_r.bus = UBF_BUS_ACK;
				end
			end
			UBF_BUS_ACK: begin
				next_r.bus = UBF_BUS_IDLE;
			end
			default: begin
				next_r.bus = UBF_BUS_IDLE;
			end
		endcase

		if (req && !wb_we_i) begin
			case (wb_adr_i)
				`UBF_OFS_DIV: next_r.rdat = {24'h000000, r.div};
				`UBF_OFS_FCR: next_r.rdat = {21'h000000, r.fcr};
				`UBF_OFS_MODE: next_r.rdat = {30'h00000000, r.cks};
				`UBF_OFS_CNT: next_r.rdat = {16'h0000, 3'h0, tx_cnt, 3'h0, rx_cnt};
				`UBF_OFS_RXD: next_r.rdat = {24'h000000, rx_byte};
				`UBF_OFS_STAT: next_r.rdat = {28'h0000000, r.stat};
				`UBF_OFS_IEN: next_r.rdat = {28'h0000000, r.ien};
				default: next_r.rdat = 32'h00000000;
			endcase
		end

		if (req && wb_we_i) begin
			case (wb_adr_i)
				`UBF_OFS_DIV: begin
					if (wb_sel_i[0]) begin
						next_r.div = wb_dat_i[7:0];
					end
				end
				`UBF_OFS_FCR: begin
					if (wb_sel_i[0]) begin
						next_r.fcr[7:0] = wb_dat_i[7:0];
					end
					if (wb_sel_i[1]) begin
						next_r.fcr[10:8] = wb_dat_i[10:8];
					end
				end
				`UBF_OFS_MODE: begin
					if (wb_sel_i[0]) begin
						next_r.cks = wb_dat_i[1:0];
					end
				end
				`UBF_OFS_IEN: begin
					if (wb_sel_i[0]) begin
						next_r.ien = wb_dat_i[`UBF_ST_W-1:0];
					end
				end
				default: begin
					next_r.div = r.div;
				end
			endcase
		end

		// sticky status: a new event beats a clear in the same cycle
		next_r.stat = (r.stat & ~clr) | events;

		// baud chain: prescaler, divisor, halving, sixteen samples
		if (pre_tick) begin
			next_r.pcnt = 6'h00;
			if (r.dcnt >= r.div) begin
				next_r.dcnt = 8'h00;
				next_r.half = !r.half;
				if (r.half) begin
					next_r.stick = 1'b1;
					next_r.scnt = r.scnt + 4'h1;
					if (r.scnt == `UBF_SMP_LAST) begin
						next_r.btick = 1'b1;
					end
				end
			end else begin
				next_r.dcnt = r.dcnt + 8'h01;
			end
		end else begin
			next_r.pcnt = r.pcnt + 6'h01;
		end

		// flow control; forced low when modem control is off
		next_r.rts = modem_control_enable && (rx_cnt > rts_thr);

		if (rst_i) begin
			next_r.bus = UBF_BUS_IDLE;
			next_r.rdat = 32'h00000000;
			next_r.div = `UBF_DIV_RST;
			next_r.fcr = `UBF_FCR_RST;
			next_r.cks = 2'h0;
			next_r.stat = '0;
			next_r.ien = '0;
			next_r.pcnt = 6'h00;
			next_r.dcnt = 8'h00;
			next_r.half = 1'b0;
			next_r.scnt = 4'h0;
			next_r.stick = 1'b0;
			next_r.btick = 1'b0;
			next_r.rts = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		r <= next_r;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign wb_ack_o = (r.bus == UBF_BUS_ACK);
	assign wb_dat_o = r.rdat;
	assign irq_o = |(r.stat & r.ien);
	assign sample_tick_o = r.stick;
	assign bit_tick_o = r.btick;
	assign request_to_send_out_o = r.rts;
	assign serial_tx_pin_o = loop ? 1'b1 : tx_serial_i;
	assign rx_serial_o = loop ? tx_serial_i : serial_rx_pin_i;
	assign cts_eff_n_o = modem_control_enable ? (loop ? r.rts : clear_to_send_in_n_i) : 1'b0;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	reset_values_a: assert property ($fell(rst_i) |-> r.div == 8'hFF && r.fcr == 11'h000)
		else $error("divisor or control not at reset value");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	div_write_a: assert property (req && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0]
		|=> wb_ack_o && r.div == $past(wb_dat_i[7:0]))
		else $error("divisor write not stored");
	rts_modem_off_a: assert property (!modem_control_enable |=> !request_to_send_out_o)
		else $error("rts high with modem control off");
	rts_raise_a: assert property (modem_control_enable && rx_cnt > rts_thr |=> request_to_send_out_o)
		else $error("rts low above threshold");
	rts_drop_a: assert property (rx_cnt <= rts_thr |=> !request_to_send_out_o)
		else $error("rts high within threshold");
	rx_full_a: assert property (rx_cnt >= rx_trg |=> r.stat[0])
		else $error("rx full flag missing");
	tx_empty_a: assert property (tx_cnt <= tx_trg |=> r.stat[1])
		else $error("tx empty flag missing");
	rx_reset_a: assert property (r.fcr[1] |=> rx_cnt == 5'h00 && !rx_avail)
		else $error("rx fifo not held empty");
	loop_cts_a: assert property (modem_control_enable && loop |-> cts_eff_n_o == request_to_send_out_o)
		else $error("loopback cts not fed from rts");
	fcr_upper_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h04
		|-> wb_dat_o[31:11] == 21'h000000)
		else $error("control upper bits not zero");
	tx_reset_a: assert property (r.fcr[`UBF_FCR_TX_FIFO_RESET] |=> tx_cnt == 5'h00 && !tx_valid_o)
		else $error("tx fifo not held empty");
	div_hold_a: assert property (!(req && wb_we_i && wb_adr_i == `UBF_OFS_DIV)
		|=> $stable(r.div))
		else $error("divisor changed without a write");
	tick_gap_a: assert property (sample_tick_o |=> !sample_tick_o)
		else $error("sample ticks back to back");
	bit_on_sample_a: assert property (bit_tick_o |-> sample_tick_o)
		else $error("bit tick off a sample tick");
	cts_forced_a: assert property (!modem_control_enable |-> !cts_eff_n_o)
		else $error("cts not forced active");
	fcr_write_a: assert property (req && wb_we_i && wb_sel_i[0]
		&& wb_adr_i == `UBF_OFS_FCR |=> r.fcr[7:0] == $past(wb_dat_i[7:0]))
		else $error("control write not stored");
	cnt_read_a: assert property (wb_ack_o && !$past(wb_we_i)
		&& $past(wb_adr_i) == `UBF_OFS_CNT
		|-> wb_dat_o == {16'h0000, 3'h0, $past(tx_cnt), 3'h0, $past(rx_cnt)})
		else $error("count register read wrong");
	tx_drop_a: assert property (req && wb_we_i && wb_adr_i == `UBF_OFS_TXD
		&& tx_cnt == `UBF_DEPTH |=> r.stat[`UBF_ST_TXDROP])
		else $error("dropped tx write not flagged");
endmodule // ubf_uart_ctrl
`default_nettype wire

/* ubf_far_model.sv */
// ubf_far_model.sv - far side of the control block: engine and line stand-in
// assumes: one clock; push_i pulses one cycle per byte offered
`timescale 1ns/1ps
`default_nettype none
module ubf_far_model (
	input wire logic clk_i, // clock
	input wire logic rst_i, // sync reset
	input wire logic push_i, // offer one rx byte
	input wire logic [7:0] push_data_i, // byte to offer
	input wire logic hold_i, // stall the tx side
	input wire logic tx_valid_i, // tx byte ready
	input wire logic [7:0] tx_data_i, // tx byte
	output logic tx_ready_o, // tx byte taken
	input wire logic rx_ready_i, // rx fifo room
	output logic rx_valid_o, // rx byte offered
	output logic [7:0] rx_data_o // rx byte
);
	logic [7:0] got [0:15];
	logic [4:0] n_got;
	logic [7:0] last;
	assign tx_ready_o = !hold_i;
	// released data shows the inverse of the last byte
	assign rx_data_o = rx_valid_o ? last : ~last;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_valid_o <= 1'b0;
			n_got <= 5'h00;
			last <= 8'h00;
		end else begin
			if (push_i) begin
				rx_valid_o <= 1'b1;
				last <= push_data_i;
			end else if (rx_valid_o && rx_ready_i) begin
				rx_valid_o <= 1'b0;
			end
			if (tx_valid_i && tx_ready_o) begin
				got[n_got[3:0]] <= tx_data_i;
				n_got <= n_got + 5'h01;
			end
		end
	end
endmodule // ubf_far_model
`default_nettype wire

/* tb.sv */
// tb.sv - self-checking bench for the baud and fifo control block
// assumes: ubf_pkg, ubf_fifo, ubf_uart_ctrl, ubf_far_model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "ubf_consts.svh"
module tb;
	import ubf_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, push, hold, txs, rxp, cts_n;
	logic [7:0] adr, pd, b [0:15];
	logic [3:0] sel;
	logic [31:0] wd, rd, wdo;
	logic ack, irq, stk, btk, txv, txr, rxv, rxr, rxs, ctse, tpin, rts;
	logic [7:0] txd, rxd;
	int n_errors, compares;
	ubf_uart_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(wdo),
		.wb_ack_o(ack), .irq_o(irq), .sample_tick_o(stk), .bit_tick_o(btk),
		.tx_valid_o(txv), .tx_ready_i(txr), .tx_data_o(txd), .rx_valid_i(rxv),
		.rx_ready_o(rxr), .rx_data_i(rxd), .tx_serial_i(txs), .rx_serial_o(rxs),
		.cts_eff_n_o(ctse), .serial_tx_pin_o(tpin), .serial_rx_pin_i(rxp),
		.request_to_send_out_o(rts), .clear_to_send_in_n_i(cts_n));
	ubf_far_model far (.clk_i(clk_i), .rst_i(rst_i), .push_i(push), .push_data_i(pd),
		.hold_i(hold), .tx_valid_i(txv), .tx_data_i(txd), .tx_ready_o(txr),
		.rx_ready_i(rxr), .rx_valid_o(rxv), .rx_data_o(rxd));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			n_errors++;
			$display("BAD bus_ack expected 1 seen %b", ack);
		end
		rd = wdo;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdx(input logic [7:0] a, input string nm, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, rd, e);
	endtask
	task automatic rxpush(input logic [7:0] d);
		int n;
		n = 0;
		push <= 1'b1;
		pd <= d;
		@(posedge clk_i);
		push <= 1'b0;
		do begin
			@(posedge clk_i);
			n++;
		end while (rxv === 1'b1 && n < 20);
	endtask
	task automatic tick(input logic bt, output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while ((bt ? btk : stk) !== 1'b1 && n < 20000);
	endtask
	task automatic finish_test;
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	function automatic int rts_thr(input logic [2:0] c);
		return (c == 3'h0) ? 15 : ((c == 3'h1) ? 1 : 2 * c);
	endfunction
	function automatic int rx_trg(input logic [1:0] c);
		return (c == 2'h0) ? 1 : ((c == 2'h3) ? 14 : 4 * c);
	endfunction
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// watchdog: roughly twice the longest whole run
	initial begin
		#200000;
		n_errors++;
		finish_test;
	end
	initial begin
		int i, k, c, m, n;
		logic [31:0] dv;
		{rst_i, cyc, stb, we, push, hold, txs, rxp, cts_n} = 9'h10F;
		{adr, pd, wd, sel} = 52'hF;
		dv = $urandom(32'h8B22);
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdx(`UBF_OFS_DIV, "div_reset", 32'hFF);
		rdx(`UBF_OFS_FCR, "fcr_reset", 32'h0);
		rdx(`UBF_OFS_CNT, "cnt_reset", 32'h0);
		wr(8'h24, 32'hFFFFFFFF);
		rdx(8'h24, "unmapped", 32'h0);
		for (i = 0; i < 8; i++) begin
			dv = $urandom;
			wr(`UBF_OFS_DIV, dv);
			rdx(`UBF_OFS_DIV, "div_rw", dv & 32'hFF);
			wr(`UBF_OFS_FCR, dv & 32'h7F8);
			rdx(`UBF_OFS_FCR, "fcr_rw", dv & 32'h7F8);
		end
		sel <= 4'h1;
		wr(`UBF_OFS_FCR, 32'h7F0);
		sel <= 4'hF;
		rdx(`UBF_OFS_FCR, "fcr_lane", (dv & 32'h700) | 32'hF0);
		$display("registers done");
		for (m = 0; m < 4; m++) begin
			dv = $urandom % 4;
			wr(`UBF_OFS_DIV, dv);
			wr(`UBF_OFS_MODE, m);
			repeat (3) tick(1'b0, n);
			chk("sample_period", n, 2 * (dv + 1) * (1 << (2 * m)));
			repeat (2) tick(1'b1, n);
			chk("bit_period", n, 32 * (dv + 1) * (1 << (2 * m)));
		end
		$display("baud done");
		for (c = 0; c < 8; c++) begin
			wr(`UBF_OFS_FCR, (c << 8) | ((c & 3) << 6) | 10);
			rdx(`UBF_OFS_CNT, "rx_flushed", 32'h0);
			wr(`UBF_OFS_FCR, (c << 8) | ((c & 3) << 6) | 8);
			wr(`UBF_OFS_CLR, 32'hF);
			for (k = 1; k <= 16; k++) begin
				b[k - 1] = $urandom;
				rxpush(b[k - 1]);
				rdx(`UBF_OFS_CNT, "rx_count", k);
				chk("rts", rts, k > rts_thr(c));
				bus(1'b0, `UBF_OFS_STAT, 32'h0);
				chk("rx_full", rd[0], k >= rx_trg(c));
			end
			chk("rx_ready_full", rxr, 1'b0);
			for (k = 0; k < 8; k++) rdx(`UBF_OFS_RXD, "rx_data", b[k]);
			chk("rts_drain", rts, 8 > rts_thr(c));
		end
		$display("rx fifo done");
		for (c = 0; c < 4; c++) begin
			wr(`UBF_OFS_FCR, (c << 4) | 6);
			rdx(`UBF_OFS_CNT, "fifos_flushed", 32'h0);
			wr(`UBF_OFS_FCR, c << 4);
			for (k = 1; k <= 16; k++) begin
				b[k - 1] = $urandom;
				wr(`UBF_OFS_TXD, b[k - 1]);
				wr(`UBF_OFS_CLR, 32'h2);
				bus(1'b0, `UBF_OFS_STAT, 32'h0);
				chk("tx_empty", rd[1], k <= (8 >> c));
			end
			wr(`UBF_OFS_TXD, 32'hA5);
			bus(1'b0, `UBF_OFS_STAT, 32'h0);
			chk("tx_drop", rd[2], 1'b1);
			rdx(`UBF_OFS_CNT, "tx_full", 32'h1000);
			wr(`UBF_OFS_CLR, 32'h2);
			wr(`UBF_OFS_IEN, 32'h2);
			chk("irq_quiet", irq, 1'b0);
			if (c < 3) begin
				wr(`UBF_OFS_FCR, (c << 4) | 4);
				rdx(`UBF_OFS_CNT, "tx_reset", 32'h0);
			end else begin
				hold <= 1'b0;
				repeat (20) @(posedge clk_i);
				for (k = 0; k < 16; k++) chk("tx_out", far.got[k], b[k]);
				hold <= 1'b1;
			end
			chk("irq_on", irq, 1'b1);
			wr(`UBF_OFS_IEN, 32'h0);
			chk("irq_mask", irq, 1'b0);
		end
		$display("tx fifo done");
		wr(`UBF_OFS_FCR, 32'h108);
		repeat (2) rxpush($urandom);
		for (i = 0; i < 16; i++) begin
			m = $urandom;
			wr(`UBF_OFS_FCR, (m & 9) | 32'h100);
			txs <= m[4];
			rxp <= m[5];
			cts_n <= m[6];
			repeat (2) @(posedge clk_i);
			chk("rts_gate", rts, m[3]);
			chk("cts_eff", ctse, m[3] & (m[0] | m[6]));
			chk("rx_serial", rxs, m[0] ? m[4] : m[5]);
			chk("tx_pin", tpin, m[0] | m[4]);
		end
		$display("modem and loopback done");
		wr(`UBF_OFS_DIV, 32'h12);
		wr(`UBF_OFS_TXD, 32'h77);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdx(`UBF_OFS_DIV, "div_rereset", 32'hFF);
		rdx(`UBF_OFS_FCR, "fcr_rereset", 32'h0);
		rdx(`UBF_OFS_CNT, "cnt_rereset", 32'h0);
		$display("second reset done");
		finish_test;
	end
endmodule // tb
`default_nettype wire
